// file: design/cifc_consts.vh
// Purpose: Constants of the camera input front configuration block
// Assumes: Included by the design files of this block and by its bench
// Notes: What follows is the list of behaviours kept by the block
// What this block does
// - Bit 31 picks embedded or external sync
// - Bit 30 adds 128 to chroma samples
// - Line width held in bits 28:16, multiple eight; the block uses any value written there as is
// - Bits 15:14 choose the 4:2:2 component order
// - Frame height held in bits 12:0
// - Crop only when window enable bit set
// - Window bit 30 clears codec luma overflow
// - Bits 15, 14 clear codec chroma overflows
// - Bits 13, 12 clear preview chroma overflows
// - Twice horizontal offset removed from line width
// - Control bit 31 soft-resets the capture interface
// - Control bit 30 drives camera reset pin
// - Control bit 29 reads one after reset
// - Bits 28:27 select camera or test pattern
// - Bits 26:24 invert pixel clock and syncs
// - Capture, pattern, crop window and format bits 30:0 take effect at frame sync fall
// - Embedded mode decodes codes after FF-00-00
`ifndef CIFC_CONSTS_VH
`define CIFC_CONSTS_VH
`define CIFC_ADDR_SRC 32'h4f000000
`define CIFC_ADDR_WIN 32'h4f000004
`define CIFC_ADDR_GCTRL 32'h4f000008
`define CIFC_ADDR_CTRL 32'h4f000014
`define CIFC_SRC_MASK 32'hdfffdfff
`define CIFC_WIN_MASK 32'hc7fff7ff
`define CIFC_GCTRL_MASK 32'hff000000
`define CIFC_CTRL_MASK 32'h00000001
`define CIFC_SRC_RST 32'h00000000
`define CIFC_WIN_RST 32'h00000000
`define CIFC_GCTRL_RST 32'h20000000
`define CIFC_CTRL_RST 32'h00000000
`define CIFC_SRC_STYLE 31
`define CIFC_SRC_CHROMA 30
`define CIFC_SRC_WIDTH 28:16
`define CIFC_SRC_ORDER 15:14
`define CIFC_SRC_HEIGHT 12:0
`define CIFC_WIN_CROP 31
`define CIFC_WIN_CLR_CY 30
`define CIFC_WIN_HOFS 26:16
`define CIFC_WIN_CLR_CCB 15
`define CIFC_WIN_CLR_CCR 14
`define CIFC_WIN_CLR_PCB 13
`define CIFC_WIN_CLR_PCR 12
`define CIFC_WIN_VOFS 10:0
`define CIFC_GC_INTERFACE_SOFT_RESET 31
`define CIFC_GC_CAMERA_RESET_OUT_CTL 30
`define CIFC_GC_PATTERN 28:27
`define CIFC_GC_INV_PCLK 26
`define CIFC_GC_INV_FS 25
`define CIFC_GC_INV_LS 24
`define CIFC_CTRL_CAPTURE 0
`define CIFC_RESP_OKAY 2'h0
`define CIFC_RESP_SLVERR 2'h2
`define CIFC_KIND_Y 2'h0
`define CIFC_KIND_CB 2'h1
`define CIFC_KIND_CR 2'h2
`define CIFC_PAT_CAMERA 2'h0
`define CIFC_PAT_BARS 2'h1
`define CIFC_PAT_HINC 2'h2
`define CIFC_PAT_VINC 2'h3
`define CIFC_CHROMA_OFS 8'h80
`define CIFC_PREAMBLE 24'hff0000
`define CIFC_BYTE_FF 8'hff
`define CIFC_CODE_V 5
`define CIFC_CODE_H 4
`endif

// file: design/cifc_sync2.v
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent level from outside the clock domain
// Notes: Only the second stage leaves this module
`timescale 1ns/1ns
module cifc_sync2
#(
    parameter WIDTH = 11
)
(
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut_ff
)
;
reg [WIDTH-1:0] stage1_ff;

// First stage feeds the second and nothing else, to bound metastability
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        stage1_ff <= {WIDTH{1'b0}};
        syncOut_ff <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1_ff <= asyncIn;
        syncOut_ff <= stage1_ff;
    end
end
endmodule // cifc_sync2

// file: design/cifc_top.v
// Purpose: Camera input front: AXI4-Lite registers and pixel sampling front end
// Assumes: Pixel clock much slower than clk, sampled as a plain input
// Notes: Pixel stream and overflow flags feed the capture paths downstream
`timescale 1ns/1ns
`include "cifc_consts.vh"
module cifc_top
#(
    parameter ADDR_W = 32
)
(
    input wire clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cameraPixelClock,
    input wire cameraFrameSync,
    input wire cameraLineSync,
    input wire [7:0] cameraData,
    output reg cameraResetPin_ff,
    input wire [4:0] overflowEvent,
    output reg [4:0] overflowFlags_ff,
    output reg interfaceSoftReset_ff,
    output reg captureActive_ff,
    output reg pixValid_ff,
    output reg [7:0] pixData_ff,
    output reg [1:0] pixKind_ff,
    output reg frameSync_ff
)
;
reg [31:0] sourceFormat_ff;
reg [31:0] windowOffset_ff;
reg [31:0] globalControl_ff;
reg [31:0] captureCtrl_ff;
reg [ADDR_W-1:0] wrAddr_ff;
reg awHeld_ff;
reg [31:0] wrData_ff;
reg [3:0] wrStrb_ff;
reg wHeld_ff;
reg [31:0] shadowSrc_ff;
reg [31:0] shadowWin_ff;
reg [1:0] shadowPattern_ff;
reg shadowCapture_ff;
reg pclkPrev_ff;
reg [23:0] history_ff;
reg frame656_ff;
reg active656_ff;
reg framePrev_ff;
reg linePrev_ff;
reg [13:0] byteCnt_ff;
reg [12:0] lineCnt_ff;
wire [10:0] pinSync;
wire doWrite;
wire pclkLevel;
wire pclkRise;
wire syncStyle601;
wire frameNow;
wire lineNow;
wire [12:0] pixelIdx;
wire [12:0] hOfs;
wire [12:0] vOfs;
wire [12:0] lineWidth;
wire [12:0] frameHeight;
wire inWindow;
wire [1:0] curKind;
wire [4:0] clearOverflow;
reg [7:0] patByte;
reg [7:0] rawByte;

// Byte-lane merge for a register write; reserved bits stay at zero
function [31:0] mergeStrb;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] strb;
    input [31:0] mask;
    integer i;
    begin
        mergeStrb = oldVal;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (strb[i])
            begin
                mergeStrb[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        mergeStrb = mergeStrb & mask;
    end
endfunction

// Which component a byte is, from the order field and byte phase
function [1:0] kindOf;
    input [1:0] order;
    input [1:0] phase;
    begin
        case (order)
            2'h0: kindOf = !phase[0] ? `CIFC_KIND_Y : (phase[1] ? `CIFC_KIND_CR : `CIFC_KIND_CB);
            2'h1: kindOf = !phase[0] ? `CIFC_KIND_Y : (phase[1] ? `CIFC_KIND_CB : `CIFC_KIND_CR);
            2'h2: kindOf = phase[0] ? `CIFC_KIND_Y : (phase[1] ? `CIFC_KIND_CR : `CIFC_KIND_CB);
            default: kindOf = phase[0] ? `CIFC_KIND_Y : (phase[1] ? `CIFC_KIND_CB : `CIFC_KIND_CR);
        endcase
    end
endfunction

cifc_sync2 #(.WIDTH(11)) uPinSync
(
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({cameraPixelClock, cameraFrameSync, cameraLineSync, cameraData}),
    .syncOut_ff(pinSync)
);

// Write fires once both address and data are held and the last response is gone
assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

// AXI write channels: address and data taken in either order
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        wrAddr_ff <= {ADDR_W{1'b0}};
        wrData_ff <= 32'h0;
        wrStrb_ff <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `CIFC_RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            wrAddr_ff <= s_axi_awaddr;
            awHeld_ff <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wrData_ff <= s_axi_wdata;
            wrStrb_ff <= s_axi_wstrb;
            wHeld_ff <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (doWrite)
        begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wrAddr_ff)
                `CIFC_ADDR_SRC, `CIFC_ADDR_WIN, `CIFC_ADDR_GCTRL, `CIFC_ADDR_CTRL: s_axi_bresp <= `CIFC_RESP_OKAY;
                default: s_axi_bresp <= `CIFC_RESP_SLVERR;
            endcase
        end
        // Readies return only once the response is accepted, so one write is in flight
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// Register file; reserved bits are masked so they read as their fixed value
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sourceFormat_ff <= `CIFC_SRC_RST;
        windowOffset_ff <= `CIFC_WIN_RST;
        globalControl_ff <= `CIFC_GCTRL_RST;
        captureCtrl_ff <= `CIFC_CTRL_RST;
    end
    else if (doWrite)
    begin
        case (wrAddr_ff)
            `CIFC_ADDR_SRC: sourceFormat_ff <= mergeStrb(sourceFormat_ff, wrData_ff, wrStrb_ff, `CIFC_SRC_MASK);
            `CIFC_ADDR_WIN: windowOffset_ff <= mergeStrb(windowOffset_ff, wrData_ff, wrStrb_ff, `CIFC_WIN_MASK);
            `CIFC_ADDR_GCTRL: globalControl_ff <= mergeStrb(globalControl_ff, wrData_ff, wrStrb_ff, `CIFC_GCTRL_MASK);
            `CIFC_ADDR_CTRL: captureCtrl_ff <= mergeStrb(captureCtrl_ff, wrData_ff, wrStrb_ff, `CIFC_CTRL_MASK);
            default: captureCtrl_ff <= captureCtrl_ff;
        endcase
    end
end

// AXI read channel: answer one cycle after the address is taken
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `CIFC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CIFC_RESP_OKAY;
        case (s_axi_araddr)
            `CIFC_ADDR_SRC: s_axi_rdata <= sourceFormat_ff;
            `CIFC_ADDR_WIN: s_axi_rdata <= windowOffset_ff;
            `CIFC_ADDR_GCTRL: s_axi_rdata <= globalControl_ff;
            `CIFC_ADDR_CTRL: s_axi_rdata <= {22'h0, frameSync_ff, overflowFlags_ff, 3'h0, captureCtrl_ff[0]};
            default:
            begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `CIFC_RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

// Clear bits in window order: codec Y, Cb, Cr, preview Cb, Cr
assign clearOverflow = {windowOffset_ff[`CIFC_WIN_CLR_PCR], windowOffset_ff[`CIFC_WIN_CLR_PCB],
                        windowOffset_ff[`CIFC_WIN_CLR_CCR], windowOffset_ff[`CIFC_WIN_CLR_CCB],
                        windowOffset_ff[`CIFC_WIN_CLR_CY]};

// Overflow flags: a held clear bit wins over new events until written back to 0
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        overflowFlags_ff <= 5'h0;
    end
    else if (globalControl_ff[`CIFC_GC_INTERFACE_SOFT_RESET])
    begin
        overflowFlags_ff <= 5'h0;
    end
    else
    begin
        overflowFlags_ff <= (overflowFlags_ff | overflowEvent) & ~clearOverflow;
    end
end

// Straight register outputs toward the camera and the capture paths
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cameraResetPin_ff <= 1'b0;
        interfaceSoftReset_ff <= 1'b0;
        captureActive_ff <= 1'b0;
    end
    else
    begin
        cameraResetPin_ff <= globalControl_ff[`CIFC_GC_CAMERA_RESET_OUT_CTL];
        interfaceSoftReset_ff <= globalControl_ff[`CIFC_GC_INTERFACE_SOFT_RESET];
        captureActive_ff <= shadowCapture_ff;
    end
end

// Pixel clock edge found on the synchronised, optionally inverted level
assign pclkLevel = pinSync[10] ^ globalControl_ff[`CIFC_GC_INV_PCLK];
assign pclkRise = pclkLevel && !pclkPrev_ff;
assign syncStyle601 = sourceFormat_ff[`CIFC_SRC_STYLE];
// Embedded V is read off the code byte itself, so new settings meet the first active byte; FF in video starts the end code
assign frameNow = syncStyle601 ? (pinSync[9] ^ globalControl_ff[`CIFC_GC_INV_FS])
                  : (history_ff == `CIFC_PREAMBLE ? pinSync[`CIFC_CODE_V] : frame656_ff);
assign lineNow = syncStyle601 ? (pinSync[8] ^ globalControl_ff[`CIFC_GC_INV_LS])
                 : (active656_ff && pinSync[7:0] != `CIFC_BYTE_FF);

// Crop window taken from the frame-latched copies of the registers
assign pixelIdx = byteCnt_ff[13:1];
assign hOfs = {2'h0, shadowWin_ff[`CIFC_WIN_HOFS]};
assign vOfs = {2'h0, shadowWin_ff[`CIFC_WIN_VOFS]};
assign lineWidth = shadowSrc_ff[`CIFC_SRC_WIDTH];
assign frameHeight = shadowSrc_ff[`CIFC_SRC_HEIGHT];
assign inWindow = !shadowWin_ff[`CIFC_WIN_CROP]
                  || (pixelIdx >= hOfs && pixelIdx < lineWidth - hOfs
                      && lineCnt_ff >= vOfs && lineCnt_ff < frameHeight - vOfs);
assign curKind = kindOf(shadowSrc_ff[`CIFC_SRC_ORDER], byteCnt_ff[1:0]);

// Byte source: camera data or one of the generated patterns
always @*
begin
    case (shadowPattern_ff)
        `CIFC_PAT_BARS: patByte = {pixelIdx[7:5], 5'h0};
        `CIFC_PAT_HINC: patByte = pixelIdx[7:0];
        `CIFC_PAT_VINC: patByte = lineCnt_ff[7:0];
        default: patByte = pinSync[7:0];
    endcase
    rawByte = patByte;
    if (shadowPattern_ff != `CIFC_PAT_CAMERA && curKind != `CIFC_KIND_Y)
    begin
        rawByte = `CIFC_CHROMA_OFS;
    end
end

// Sampling front end, stepped once per rising pixel clock edge
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pclkPrev_ff <= 1'b0;
        history_ff <= 24'h0;
        frame656_ff <= 1'b0;
        active656_ff <= 1'b0;
        framePrev_ff <= 1'b0;
        linePrev_ff <= 1'b0;
        byteCnt_ff <= 14'h0;
        lineCnt_ff <= 13'h0;
        shadowSrc_ff <= `CIFC_SRC_RST;
        shadowWin_ff <= `CIFC_WIN_RST;
        shadowPattern_ff <= `CIFC_PAT_CAMERA;
        shadowCapture_ff <= 1'b0;
        pixValid_ff <= 1'b0;
        pixData_ff <= 8'h0;
        pixKind_ff <= `CIFC_KIND_Y;
        frameSync_ff <= 1'b0;
    end
    else if (globalControl_ff[`CIFC_GC_INTERFACE_SOFT_RESET])
    begin
        // Soft reset holds the whole front end idle; settings stay intact
        pclkPrev_ff <= pclkLevel;
        history_ff <= 24'h0;
        frame656_ff <= 1'b0;
        active656_ff <= 1'b0;
        framePrev_ff <= 1'b0;
        linePrev_ff <= 1'b0;
        byteCnt_ff <= 14'h0;
        lineCnt_ff <= 13'h0;
        shadowCapture_ff <= 1'b0;
        pixValid_ff <= 1'b0;
        frameSync_ff <= 1'b0;
    end
    else
    begin
        pclkPrev_ff <= pclkLevel;
        pixValid_ff <= 1'b0;
        if (pclkRise)
        begin
            history_ff <= {history_ff[15:0], pinSync[7:0]};
            // Code byte after the preamble carries the V and H bits
            if (history_ff == `CIFC_PREAMBLE)
            begin
                frame656_ff <= pinSync[`CIFC_CODE_V];
                active656_ff <= !pinSync[`CIFC_CODE_H] && !pinSync[`CIFC_CODE_V];
            end
            else if (pinSync[7:0] == `CIFC_BYTE_FF)
            begin
                active656_ff <= 1'b0;
            end
            framePrev_ff <= frameNow;
            frameSync_ff <= frameNow;
            // Settings are latched only here, so a frame never sees a half update
            if (framePrev_ff && !frameNow)
            begin
                shadowSrc_ff <= sourceFormat_ff;
                shadowWin_ff <= windowOffset_ff;
                shadowPattern_ff <= globalControl_ff[`CIFC_GC_PATTERN];
                shadowCapture_ff <= captureCtrl_ff[`CIFC_CTRL_CAPTURE];
                lineCnt_ff <= 13'h0;
            end
            else if (linePrev_ff && !lineNow)
            begin
                lineCnt_ff <= lineCnt_ff + 13'h1;
            end
            linePrev_ff <= lineNow;
            byteCnt_ff <= lineNow ? byteCnt_ff + 14'h1 : 14'h0;
            if (lineNow && shadowCapture_ff && inWindow)
            begin
                pixValid_ff <= 1'b1;
                pixKind_ff <= curKind;
                pixData_ff <= (curKind != `CIFC_KIND_Y && shadowSrc_ff[`CIFC_SRC_CHROMA])
                              ? rawByte + `CIFC_CHROMA_OFS : rawByte;
            end
        end
    end
end
endmodule // cifc_top

// file: sim/cifc_properties.sv
// Purpose: Port-level assertions for the camera input front
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every cifc_top instance
`timescale 1ns/1ns
module cifc_props
(
    input wire clk,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire cameraResetPin_ff,
    input wire interfaceSoftReset_ff,
    input wire pixValid_ff,
    input wire [4:0] overflowEvent,
    input wire [4:0] overflowFlags_ff
);
    // Single domain, so clock and reset are stated once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready high again before response");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not closed");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped while stalled");
    // Pins may only move right after a register write completes
    AST_CAM_RESET: assert property ($changed(cameraResetPin_ff) |-> $past(s_axi_bvalid))
        else $error("camera reset pin moved without a write");
    AST_SOFT_RESET: assert property ($changed(interfaceSoftReset_ff) |-> $past(s_axi_bvalid))
        else $error("soft reset moved without a write");
    AST_SOFT_IDLE: assert property (interfaceSoftReset_ff |-> !pixValid_ff && overflowFlags_ff == 5'h00)
        else $error("front end active in soft reset");
    // Bus clock is much faster, so valid pulses must be at least nine cycles apart
    AST_PIX_PULSE: assert property (pixValid_ff |=> !pixValid_ff [*8])
        else $error("pixel pulses too close");
    AST_OVF_CAUSE: assert property ((overflowFlags_ff & ~$past(overflowFlags_ff) & ~$past(overflowEvent)) == 5'h00)
        else $error("overflow flag set without event");
endmodule // cifc_props

bind cifc_top cifc_props i_cifc_props (.*);

// file: sim/cifc_cam_model.sv
// Purpose: Behavioural camera processor driving the pixel link
// Assumes: Caller sequences syncs and bytes one pixel clock at a time
// Notes: Clock parks between calls, as a real sensor may stop it
`timescale 1ns/1ns
module cifc_cam_model
(
    input wire invClk,
    output reg pclk,
    output reg frameSync,
    output reg lineSync,
    output reg [7:0] pixBus
);
    // Known idle levels at time zero
    initial
    begin
        pclk = 1'h0;
        frameSync = 1'h0;
        lineSync = 1'h0;
        pixBus = 8'h00;
    end
    // One 125 ns byte; pins change on the inactive edge for a half period of setup
    task cyc(input f, input l, input v, input [7:0] b);
    begin
        pclk = invClk;
        frameSync = f;
        lineSync = l;
        pixBus = v ? b : ~pixBus; // Undriven bus never repeats the last byte
        #62;
        pclk = ~invClk;
        #63;
    end
    endtask
endmodule // cifc_cam_model

// file: sim/tb_cifc_top.sv
// Purpose: Self-checking bench for the camera input front
// Assumes: Pixel link driven by cifc_cam_model
// Notes: Expected bytes are queued per frame and popped at each valid pulse
`timescale 1ns/1ns
`include "cifc_consts.vh"
module tb_cifc_top;
    reg clk, rst_n, awvalid, wvalid, bready, arvalid, rready, invClk, ch, inv;
    reg [31:0] awaddr, wdata, araddr, rd;
    reg [4:0] ovfEv, ev;
    reg [1:0] rs, o, p;
    reg [7:0] d;
    wire awready, wready, bvalid, arready, rvalid, pclk, fs, ls, camera_reset_out_ctl, interface_soft_reset, pixValid, capAct, fsOut;
    wire [1:0] bresp, rresp, pixKind;
    wire [31:0] rdata;
    wire [7:0] camData, pixData;
    wire [4:0] ovfFlags;
    integer n_mismatch, total_checks, seed, t, k, ln;
    reg [9:0] expQ[$];
    reg [31:0] adr [0:3] = '{`CIFC_ADDR_SRC, `CIFC_ADDR_WIN, `CIFC_ADDR_GCTRL, `CIFC_ADDR_CTRL};
    reg [31:0] rstv [0:3] = '{`CIFC_SRC_RST, `CIFC_WIN_RST, `CIFC_GCTRL_RST, `CIFC_CTRL_RST};
    reg [31:0] msk [0:3] = '{`CIFC_SRC_MASK, `CIFC_WIN_MASK, `CIFC_GCTRL_MASK, `CIFC_CTRL_MASK};
    reg [31:0] clr [0:4] = '{32'h40000000, 32'h00008000, 32'h00004000, 32'h00002000, 32'h00001000};
    reg [7:0] code [0:11] = '{8'hff, 8'h00, 8'h00, 8'hb0, 8'hff, 8'h00, 8'h00, 8'h80, 8'hff, 8'h00, 8'h00, 8'h90};

    cifc_top i_cifc_top
    (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cameraPixelClock(pclk), .cameraFrameSync(fs),
        .cameraLineSync(ls), .cameraData(camData), .cameraResetPin_ff(camera_reset_out_ctl), .overflowEvent(ovfEv),
        .overflowFlags_ff(ovfFlags), .interfaceSoftReset_ff(interface_soft_reset), .captureActive_ff(capAct),
        .pixValid_ff(pixValid), .pixData_ff(pixData), .pixKind_ff(pixKind), .frameSync_ff(fsOut)
    );
    cifc_cam_model i_cifc_cam_model
    (
        .invClk(invClk), .pclk(pclk), .frameSync(fs), .lineSync(ls), .pixBus(camData)
    );

    // 100 MHz system clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task stop_test;
    begin
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // Write: address and data offered together, each dropped once taken
    task axw(input [31:0] a, input [31:0] v, output [1:0] r);
        integer n;
    begin
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        r = 2'h3;
        for (n = 0; n < 50 && r === 2'h3; n = n + 1)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1)
            begin
                r = bresp;
                bready <= 1'h0;
            end
        end
        if (r === 2'h3) chk(32'h0, 32'h1);
    end
    endtask

    task axr(input [31:0] a, output [31:0] v, output [1:0] r);
        integer n;
    begin
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r = 2'h3;
        for (n = 0; n < 50 && r === 2'h3; n = n + 1)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1)
            begin
                v = rdata;
                r = rresp;
                rready <= 1'h0;
            end
        end
        if (r === 2'h3) chk(32'h0, 32'h1);
    end
    endtask

    // Reference byte: kind from phase and order, value from source or pattern
    function [9:0] expByte(input [1:0] ord, input [1:0] pat, input c, input integer lnI, input integer kI,
        input [7:0] b);
        reg [1:0] kd;
        reg [7:0] v;
    begin
        kd = (kI[0] == ord[1]) ? `CIFC_KIND_Y : ((kI[1] ^ ord[0]) ? `CIFC_KIND_CR : `CIFC_KIND_CB);
        if (pat == `CIFC_PAT_CAMERA) v = (c && kd != `CIFC_KIND_Y) ? b + `CIFC_CHROMA_OFS : b;
        else if (kd != `CIFC_KIND_Y) v = 8'h80;
        else if (pat == `CIFC_PAT_BARS) v = {kI[8:6], 5'h00};
        else if (pat == `CIFC_PAT_HINC) v = kI[8:1];
        else v = lnI[7:0];
        expByte = {kd, v};
    end
    endfunction

    // 601 frame: sync pulse then two lines of 32 bytes; crop keeps pixels 4 to 11
    task frame601(input crop);
    begin
        for (k = 0; k < 4; k = k + 1) i_cifc_cam_model.cyc(inv ^ (k < 2), inv, 1'h0, 8'h00);
        for (ln = 0; ln < 2; ln = ln + 1)
        begin
            for (k = 0; k < 32; k = k + 1)
            begin
                d = $random(seed);
                if (!crop || (k >= 8 && k < 24)) expQ.push_back(expByte(o, p, ch, ln, k, d));
                i_cifc_cam_model.cyc(inv, !inv, 1'h1, d);
            end
            for (k = 0; k < 2; k = k + 1) i_cifc_cam_model.cyc(inv, inv, 1'h0, 8'h00);
        end
        repeat (8) @(posedge clk);
        chk(expQ.size(), 0);
        chk({capAct, fsOut}, 2'h2);
    end
    endtask

    // Every emitted byte must match the head of the reference queue
    always @(posedge clk)
    begin
        if (pixValid === 1'h1)
        begin
            if (expQ.size() == 0) chk(32'h1, 32'h0);
            else chk({pixKind, pixData}, expQ.pop_front());
        end
    end

    // Watchdog, well beyond the expected run
    initial
    begin
        #600000;
        n_mismatch = n_mismatch + 1;
        stop_test;
    end

    initial
    begin
        seed = 10798;
        n_mismatch = 0;
        total_checks = 0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, invClk, inv, ch} = 9'h000;
        {awaddr, wdata, araddr} = 96'h0;
        ovfEv = 5'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        // Reset values, then all-ones write showing which bits hold
        for (t = 0; t < 4; t = t + 1)
        begin
            axr(adr[t], rd, rs);
            chk(rd, rstv[t]);
            axw(adr[t], 32'hffffffff, rs);
            chk(rs, `CIFC_RESP_OKAY);
            axr(adr[t], rd, rs);
            chk(rd & (t == 3 ? 32'h1 : 32'hffffffff), msk[t]);
        end
        chk({interface_soft_reset, camera_reset_out_ctl}, 2'h3);
        axw(32'h4f00000c, 32'hffffffff, rs);
        chk(rs, `CIFC_RESP_SLVERR);
        axr(32'h4f00000c, rd, rs);
        chk({rd, rs}, {32'h0, `CIFC_RESP_SLVERR});
        axw(`CIFC_ADDR_GCTRL, `CIFC_GCTRL_RST, rs);
        axw(`CIFC_ADDR_CTRL, 32'h0, rs);
        repeat (2) @(posedge clk);
        chk({interface_soft_reset, camera_reset_out_ctl}, 2'h0);
        // Each clear bit keeps only its own flag down while events arrive
        for (t = 0; t < 5; t = t + 1)
        begin
            ev = $random(seed) | (5'h01 << t);
            axw(`CIFC_ADDR_WIN, 32'h4000f000, rs);
            axw(`CIFC_ADDR_WIN, clr[t], rs);
            @(posedge clk);
            ovfEv <= ev;
            @(posedge clk);
            ovfEv <= 5'h00;
            repeat (2) @(posedge clk);
            chk(ovfFlags, ev & ~(5'h01 << t));
            axr(`CIFC_ADDR_CTRL, rd, rs);
            chk(rd[8:4], ev & ~(5'h01 << t));
        end
        axw(`CIFC_ADDR_CTRL, 32'h1, rs);
        // 601 runs: four orders, three patterns, then inverted syncs with crop
        for (t = 0; t < 8; t = t + 1)
        begin
            o = (t < 4) ? t : ((t == 7) ? $random(seed) : 2'h0);
            p = (t >= 4 && t < 7) ? t - 3 : 2'h0;
            ch = (p == 2'h0) ? $random(seed) : 1'h0;
            inv = (t == 7);
            axw(`CIFC_ADDR_SRC, {1'h1, ch, 1'h0, 13'h010, o, 1'h0, 13'h0002}, rs);
            axw(`CIFC_ADDR_WIN, inv ? 32'h80040000 : 32'h0, rs);
            axw(`CIFC_ADDR_GCTRL, {3'h1, p, {3{inv}}, 24'h000000}, rs);
            invClk = inv;
            frame601(inv);
        end
        // 656 run: sync codes after the preamble, codes never emitted
        inv = 1'h0;
        invClk = 1'h0;
        o = 2'h0;
        p = 2'h0;
        axw(`CIFC_ADDR_GCTRL, `CIFC_GCTRL_RST, rs);
        axw(`CIFC_ADDR_WIN, 32'h0, rs);
        axw(`CIFC_ADDR_SRC, {1'h0, ch, 1'h0, 13'h010, 2'h0, 1'h0, 13'h0002}, rs);
        for (k = 0; k < 8; k = k + 1) i_cifc_cam_model.cyc(1'h0, 1'h0, 1'h1, code[k]);
        for (k = 0; k < 16; k = k + 1)
        begin
            d = $random(seed) & 8'h7f;
            expQ.push_back(expByte(o, p, ch, 0, k, d));
            i_cifc_cam_model.cyc(1'h0, 1'h0, 1'h1, d);
        end
        for (k = 8; k < 12; k = k + 1) i_cifc_cam_model.cyc(1'h0, 1'h0, 1'h1, code[k]);
        repeat (8) @(posedge clk);
        chk(expQ.size(), 0);
        stop_test;
    end
endmodule // tb_cifc_top
